/* File: tdma_top.sv */
// two-channel dma engine: apb registers, descriptor fetch and data mover
`include "tdma_cfg.svh"
module tdma_top
  import tdma_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] ext_dma_request_n_i,
  output logic bus_req_o,
  input wire logic bus_gnt_i,
  output tdma_mem_req_t mem_req_o,
  input wire logic mem_ready_i,
  input wire logic mem_err_i,
  input wire logic [31:0] mem_rdata_i,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  tdma_ctl_t ctl [2];
  logic [31:0] srcb [2];
  logic [31:0] dstb [2];
  logic [`TDMA_CNT_W-1:0] tcnt [2];
  logic [31:0] csrc [2];
  logic [31:0] cdst [2];
  logic [`TDMA_CNT_W-1:0] ctcnt [2];
  tdma_dadr_t dadr [2];
  logic [31:0] nxt_desc [2];
  logic [1:0] active;
  logic [1:0] desc_pend;
  logic [1:0] desc_mode;
  logic [1:0] block_run;
  logic [1:0] ext_pend;
  logic [1:0] ext_prev;
  logic [1:0] done;
  logic [1:0] err;
  tdma_state_t state;
  logic sel;
  logic [2:0] beat;
  logic [31:0] data_q;
  logic [31:0] dword [3];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic apb_wr;
  logic ch_hit;
  logic stat_hit;
  logic wch;
  logic [2:0] widx;
  assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
  assign ch_hit = (paddr_i[11:6] == 6'h00);
  assign stat_hit = (paddr_i[11:8] == 4'h0) && (paddr_i[7:0] == `TDMA_OFF_STAT);
  assign wch = paddr_i[5];
  assign widx = paddr_i[4:2];

  ////////////////////////////////////////////////////////////////////////////
  // engine strobes and per-channel request terms
  logic [1:0] ext_lvl;
  logic [1:0] io_mode;
  logic [1:0] go;
  logic [1:0] want;
  logic burst_start;
  logic unit_done;
  logic fetch_done;
  logic err_evt;
  logic last_unit;
  logic [2:0] beats;
  logic [31:0] step;
  tdma_ctl_t cmd_ctl;

  // external request is active low, taken as synchronous
  assign ext_lvl = ~ext_dma_request_n_i;

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      io_mode[c] = (ctl[c].mode == 2'b01) || (ctl[c].mode == 2'b10);
      go[c] = active[c] & ctl[c].en & (ctcnt[c] != '0)
              & (ctl[c].softreq | block_run[c]
                 | (io_mode[c] & (ctl[c].demand ? ext_lvl[c] : ext_pend[c])));
      want[c] = desc_pend[c] | go[c];
    end
  end

  assign burst_start = (state == TDMA_REQ) && bus_gnt_i && !desc_pend[sel];
  assign unit_done = (state == TDMA_WR) && mem_ready_i && !mem_err_i;
  assign fetch_done = (state == TDMA_DFETCH) && mem_ready_i && !mem_err_i && (beat == 3'h3);
  assign err_evt = (state == TDMA_DFETCH || state == TDMA_RD || state == TDMA_WR)
                   && mem_ready_i && mem_err_i;
  assign last_unit = (ctcnt[sel] == `TDMA_CNT_W'(1));
  assign cmd_ctl = tdma_ctl_t'({14'h0000, mem_rdata_i[`TDMA_CMD_CNT_LSB-1:0]});
  // burst of four, cut short by what is left of the count
  assign beats = !ctl[sel].burst ? 3'h1
                 : (ctcnt[sel] > `TDMA_CNT_W'(4)) ? `TDMA_BURST_LEN : ctcnt[sel][2:0];
  assign step = 32'h1 << ctl[sel].width;

  ////////////////////////////////////////////////////////////////////////////
  // programming registers, loaded by software and by descriptor fetch
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int c = 0; c < 2; c++)
      begin
        ctl[c] <= '0;
        srcb[c] <= '0;
        dstb[c] <= '0;
        tcnt[c] <= '0;
        dadr[c] <= tdma_dadr_t'(`TDMA_DADR_RST_VAL);
        nxt_desc[c] <= '0;
      end
    end
    else
    begin
      if (apb_wr && ch_hit)
      begin
        case (widx)
          `TDMA_OFF_CTL: ctl[wch] <= tdma_ctl_t'(pwdata_i);
          `TDMA_OFF_SRCB: srcb[wch] <= pwdata_i;
          `TDMA_OFF_DSTB: dstb[wch] <= pwdata_i;
          `TDMA_OFF_TCNT: tcnt[wch] <= pwdata_i[`TDMA_CNT_W-1:0];
          `TDMA_OFF_DADR:
          begin
            if (pwdata_i[`TDMA_DADR_BIT_CHRST])
              dadr[wch] <= tdma_dadr_t'(`TDMA_DADR_CHRST_VAL);
            else
              dadr[wch] <= tdma_dadr_t'(pwdata_i);
          end
          default: ;
        endcase
      end
      // descriptor words land where software would have put them
      if (fetch_done)
      begin
        nxt_desc[sel] <= dword[0];
        srcb[sel] <= dword[1];
        dstb[sel] <= dword[2];
        ctl[sel] <= cmd_ctl;
        tcnt[sel] <= `TDMA_CNT_W'(mem_rdata_i[31:`TDMA_CMD_CNT_LSB]);
      end
      // end of one descriptor: advance the pointer
      if (unit_done && last_unit && desc_mode[sel])
      begin
        if (dadr[sel].seq)
          dadr[sel].addr <= dadr[sel].addr + `TDMA_DESC_STRIDE;
        else
          dadr[sel] <= tdma_dadr_t'(nxt_desc[sel]);
      end
      // a failed fetch is descriptor work too
      if (err_evt && (desc_mode[sel] || desc_pend[sel]))
        dadr[sel].run <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working address and count registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int c = 0; c < 2; c++)
      begin
        csrc[c] <= '0;
        cdst[c] <= '0;
        ctcnt[c] <= '0;
      end
    end
    else
    begin
      // a direct start copies the bases and count into the working set
      if (apb_wr && ch_hit && widx == `TDMA_OFF_CTL)
      begin
        csrc[wch] <= srcb[wch];
        cdst[wch] <= dstb[wch];
        ctcnt[wch] <= tcnt[wch];
      end
      if (fetch_done)
      begin
        csrc[sel] <= dword[1];
        cdst[sel] <= dword[2];
        ctcnt[sel] <= `TDMA_CNT_W'(mem_rdata_i[31:`TDMA_CMD_CNT_LSB]);
      end
      if (unit_done)
      begin
        csrc[sel] <= ctl[sel].src_dec ? csrc[sel] - step : csrc[sel] + step;
        cdst[sel] <= ctl[sel].dst_dec ? cdst[sel] - step : cdst[sel] + step;
        ctcnt[sel] <= ctcnt[sel] - `TDMA_CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel run state
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      active <= '0;
      desc_pend <= '0;
      desc_mode <= '0;
      block_run <= '0;
    end
    else
    begin
      if (apb_wr && ch_hit && widx == `TDMA_OFF_CTL)
      begin
        active[wch] <= pwdata_i[0];
        desc_mode[wch] <= 1'b0;
        block_run[wch] <= 1'b0;
      end
      if (apb_wr && ch_hit && widx == `TDMA_OFF_DADR)
      begin
        // run set and direct-mode clear arms an immediate fetch
        desc_pend[wch] <= !pwdata_i[`TDMA_DADR_BIT_CHRST]
                          && pwdata_i[`TDMA_DADR_BIT_RUN]
                          && !pwdata_i[`TDMA_DADR_BIT_NONDESC];
        if (pwdata_i[`TDMA_DADR_BIT_CHRST] || pwdata_i[`TDMA_DADR_BIT_NONDESC])
        begin
          active[wch] <= 1'b0;
          desc_mode[wch] <= 1'b0;
        end
      end
      if (fetch_done)
      begin
        desc_pend[sel] <= 1'b0;
        desc_mode[sel] <= 1'b1;
        active[sel] <= 1'b1;
        block_run[sel] <= 1'b0;
      end
      // one request latches a block run through to zero, except io mode under descriptor control
      if (burst_start && ctl[sel].block && !(desc_mode[sel] && io_mode[sel]))
        block_run[sel] <= 1'b1;
      if (unit_done && last_unit)
      begin
        block_run[sel] <= 1'b0;
        if (desc_mode[sel])
        begin
          // follow the list while the next pointer keeps run set
          if (dadr[sel].seq)
            desc_pend[sel] <= dadr[sel].run && !dadr[sel].nondesc;
          else
            desc_pend[sel] <= nxt_desc[sel][`TDMA_DADR_BIT_RUN]
                              && !nxt_desc[sel][`TDMA_DADR_BIT_NONDESC];
          active[sel] <= 1'b0;
        end
        else
          active[sel] <= 1'b0;
      end
      if (err_evt)
      begin
        active[sel] <= 1'b0;
        desc_pend[sel] <= 1'b0;
        block_run[sel] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single-mode external requests: one falling edge, one burst
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ext_prev <= '0;
      ext_pend <= '0;
    end
    else
    begin
      ext_prev <= ext_lvl;
      for (int c = 0; c < 2; c++)
      begin
        if (ext_lvl[c] && !ext_prev[c])
          ext_pend[c] <= 1'b1;
        else if (burst_start && sel == c[0])
          ext_pend[c] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion and error flags, write one to clear, a new event wins
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      done <= '0;
      err <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        logic clr_d;
        logic clr_e;
        logic set_d;
        clr_d = apb_wr && stat_hit && pwdata_i[`TDMA_STAT_DONE_LSB + c];
        clr_e = apb_wr && stat_hit && pwdata_i[`TDMA_STAT_ERR_LSB + c];
        set_d = unit_done && last_unit && sel == c[0]
                && !(desc_mode[c] && (dadr[c].seq ? (dadr[c].run && !dadr[c].nondesc)
                     : (nxt_desc[c][`TDMA_DADR_BIT_RUN] && !nxt_desc[c][`TDMA_DADR_BIT_NONDESC])));
        if (apb_wr && ch_hit && widx == `TDMA_OFF_DADR && wch == c[0]
            && pwdata_i[`TDMA_DADR_BIT_CHRST])
        begin
          done[c] <= 1'b0;
          err[c] <= 1'b0;
        end
        else
        begin
          done[c] <= set_d | (done[c] & !clr_d);
          err[c] <= (err_evt && sel == c[0]) | (err[c] & !clr_e);
        end
      end
      irq_o <= |(done & {ctl[1].ie, ctl[0].ie});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus master sequencer, one burst per grant
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= TDMA_IDLE;
      sel <= 1'b0;
      beat <= '0;
      data_q <= '0;
      bus_req_o <= 1'b0;
      mem_req_o <= '0;
      for (int i = 0; i < 3; i++)
        dword[i] <= '0;
    end
    else
    begin
      case (state)
        TDMA_IDLE:
        begin
          if (|want)
          begin
            sel <= !want[0];
            bus_req_o <= 1'b1;
            state <= TDMA_REQ;
          end
        end
        TDMA_REQ:
        begin
          if (bus_gnt_i)
          begin
            mem_req_o.valid <= 1'b1;
            mem_req_o.write <= 1'b0;
            if (desc_pend[sel])
            begin
              mem_req_o.size <= 2'b10;
              mem_req_o.addr <= {dadr[sel].addr, 4'h0};
              beat <= '0;
              state <= TDMA_DFETCH;
            end
            else
            begin
              mem_req_o.size <= ctl[sel].width;
              mem_req_o.addr <= csrc[sel];
              beat <= beats;
              state <= TDMA_RD;
            end
          end
        end
        TDMA_DFETCH:
        begin
          if (mem_ready_i)
          begin
            if (mem_err_i || beat == 3'h3)
            begin
              mem_req_o.valid <= 1'b0;
              state <= TDMA_REL;
            end
            else
            begin
              dword[beat[1:0]] <= mem_rdata_i;
              mem_req_o.addr <= mem_req_o.addr + 32'h4;
              beat <= beat + 3'h1;
            end
          end
        end
        TDMA_RD:
        begin
          if (mem_ready_i)
          begin
            if (mem_err_i)
            begin
              mem_req_o.valid <= 1'b0;
              state <= TDMA_REL;
            end
            else
            begin
              // data passes unchanged; lane placement is the memory's
              data_q <= mem_rdata_i;
              mem_req_o.write <= 1'b1;
              mem_req_o.addr <= cdst[sel];
              mem_req_o.wdata <= mem_rdata_i;
              state <= TDMA_WR;
            end
          end
        end
        TDMA_WR:
        begin
          if (mem_ready_i)
          begin
            if (mem_err_i || last_unit || beat == 3'h1)
            begin
              mem_req_o.valid <= 1'b0;
              state <= TDMA_REL;
            end
            else
            begin
              mem_req_o.write <= 1'b0;
              mem_req_o.addr <= ctl[sel].src_dec ? csrc[sel] - step : csrc[sel] + step;
              beat <= beat - 3'h1;
              state <= TDMA_RD;
            end
          end
        end
        TDMA_REL:
        begin
          bus_req_o <= 1'b0;
          state <= TDMA_IDLE;
        end
        default: state <= TDMA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, read data and error registered
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pready_o <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !ch_hit && !stat_hit;
      prdata_o <= '0;
      if (psel_i && penable_i && !pready_o && !pwrite_i)
      begin
        if (stat_hit)
          prdata_o <= {22'h0, active, 2'h0, err, 2'h0, done};
        else if (ch_hit)
        begin
          case (widx)
            `TDMA_OFF_CTL: prdata_o <= ctl[wch];
            `TDMA_OFF_SRCB: prdata_o <= srcb[wch];
            `TDMA_OFF_DSTB: prdata_o <= dstb[wch];
            `TDMA_OFF_TCNT: prdata_o <= 32'(tcnt[wch]);
            `TDMA_OFF_CSRC: prdata_o <= csrc[wch];
            `TDMA_OFF_CDST: prdata_o <= cdst[wch];
            `TDMA_OFF_CTCNT: prdata_o <= 32'(ctcnt[wch]);
            default: prdata_o <= dadr[wch];
          endcase
        end
      end
    end
  end

endmodule

/* File: tdma_cfg.svh */
// register offsets, field positions and reset values of the two-channel dma
//
// Contract
// - two independent channels, mem/io in any direction
// - start by software or active-low external request
// - per-side increment/decrement, byte/half/word units
// - direct transfer done: idle until reprogrammed
// - single mode: one unit, or four with burst
// - block mode: one request moves all, to zero; io mode under descriptor control needs one per burst
// - demand mode: move while external request held
// - descriptor fetch needs run set, direct-mode clear
// - software start needs softreq and enable bits
// - softreq clear, mode 01/10: externally paced io
// - writing 0x04 resets pointer, disables descriptors
// - pointer write fetches four descriptor words at once
// - words load next, source, destination, control, count
// - command top fourteen bits load count, rest control
// - descriptor control supplies enable and mode fields
// - completion shown as status and interrupt request
// - stopped channel restarts by software reprogramming
// - sequential list: next descriptor at current+16
// - pointer bit0 resets channel, pointer reads 0x05
// - error in descriptor work clears run, stops
// - request bus, await grant, release per burst
`ifndef TDMA_CFG_SVH
`define TDMA_CFG_SVH
// word indexes within a channel window, channel 1 at +0x20, status at byte 0xa0
`define TDMA_OFF_CTL 3'h0
`define TDMA_OFF_SRCB 3'h1
`define TDMA_OFF_DSTB 3'h2
`define TDMA_OFF_TCNT 3'h3
`define TDMA_OFF_CSRC 3'h4
`define TDMA_OFF_CDST 3'h5
`define TDMA_OFF_CTCNT 3'h6
`define TDMA_OFF_DADR 3'h7
`define TDMA_OFF_STAT 8'ha0
// pointer register fields and values
`define TDMA_DADR_RST_VAL 32'h0000_0004
`define TDMA_DADR_CHRST_VAL 32'h0000_0005
`define TDMA_DADR_BIT_CHRST 0
`define TDMA_DADR_BIT_RUN 3
`define TDMA_DADR_BIT_NONDESC 2
`define TDMA_DESC_STRIDE 28'h000_0001
// command word split: count field on top
`define TDMA_CMD_CNT_LSB 18
`define TDMA_CNT_W 24
`define TDMA_BURST_LEN 3'h4
// status register fields
`define TDMA_STAT_DONE_LSB 0
`define TDMA_STAT_ERR_LSB 4
`define TDMA_STAT_BUSY_LSB 8
`endif

/* File: tdma_pkg.sv */
// types shared by the two-channel dma
package tdma_pkg;
  // channel control layout
  typedef struct packed {
    logic [13:0] rsv_hi;
    logic block;
    logic softreq;
    logic demand;
    logic rsv14;
    logic [1:0] width;
    logic rsv11;
    logic ie;
    logic [3:0] rsv_mid;
    logic src_dec;
    logic dst_dec;
    logic [1:0] mode;
    logic burst;
    logic en;
  } tdma_ctl_t;
  // descriptor pointer layout
  typedef struct packed {
    logic [27:0] addr;
    logic run;
    logic nondesc;
    logic seq;
    logic chrst;
  } tdma_dadr_t;
  // memory request toward the system bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tdma_mem_req_t;
  typedef enum logic [2:0] {
    TDMA_IDLE,
    TDMA_REQ,
    TDMA_DFETCH,
    TDMA_RD,
    TDMA_WR,
    TDMA_REL
  } tdma_state_t;
endpackage

/* File: tdma_monitor.sv */
// checker for the dma top ports
module tdma_monitor
  import tdma_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic bus_req_o,
  input wire logic bus_gnt_i,
  input tdma_mem_req_t mem_req_o,
  input wire logic mem_ready_i,
  input wire logic mem_err_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic irq_o
);
  logic [31:0] last_rd;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // last word read, to be written untouched
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      last_rd <= 32'h0;
    else if (mem_req_o.valid && !mem_req_o.write && mem_ready_i)
      last_rd <= mem_rdata_i;
  ////////////////////////////////////////////////////////////////////////////////
  // register port answer timing
  property p_apb_ans; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("register access unanswered");
  property p_slverr; pslverr_o |-> pready_o; endproperty
  a_slverr: assert property (p_slverr) else $error("error flag without ready");
  property p_rd_quiet; !pready_o |-> prdata_o == 32'h0; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside answer");
  // memory side: ownership, hold, release
  property p_own; mem_req_o.valid |-> bus_req_o; endproperty
  a_own: assert property (p_own) else $error("access without bus request");
  property p_grant; $rose(mem_req_o.valid) |-> $past(bus_gnt_i); endproperty
  a_grant: assert property (p_grant) else $error("access started without grant");
  property p_hold; mem_req_o.valid && !mem_ready_i |=> $stable(mem_req_o); endproperty
  a_hold: assert property (p_hold) else $error("access changed before ready");
  property p_release; $fell(mem_req_o.valid) |-> bus_req_o ##1 !bus_req_o; endproperty
  a_release: assert property (p_release) else $error("bus not released after burst");
  property p_raw; mem_req_o.valid && mem_req_o.write |-> mem_req_o.wdata == last_rd; endproperty
  a_raw: assert property (p_raw) else $error("written word differs from read");
  property p_err;
    mem_req_o.valid && mem_ready_i && mem_err_i |=> !mem_req_o.valid ##[1:3] !bus_req_o;
  endproperty
  a_err: assert property (p_err) else $error("engine kept going after error");
  c_err: cover property (mem_req_o.valid && mem_ready_i && mem_err_i);
  c_irq: cover property ($rose(irq_o));
  c_slverr: cover property (pready_o && pslverr_o);
endmodule
bind tdma_top tdma_monitor mon_u (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .bus_req_o(bus_req_o), .bus_gnt_i(bus_gnt_i), .mem_req_o(mem_req_o),
  .mem_ready_i(mem_ready_i), .mem_err_i(mem_err_i), .mem_rdata_i(mem_rdata_i), .irq_o(irq_o));

/* File: tdma_mem_model.sv */
// far-side model: bus arbiter and a small word memory with wait and error
module tdma_mem_model
  import tdma_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic bus_req_i,
  output logic bus_gnt_o,
  input tdma_mem_req_t mem_req_i,
  output logic mem_ready_o,
  output logic mem_err_o,
  output logic [31:0] mem_rdata_o,
  input wire logic [3:0] wait_i,
  input wire logic err_en_i
);
  logic [31:0] mem [0:63];
  logic [3:0] gcnt;
  logic [3:0] rcnt;
  logic flip = 1'b0;
  // grant after wait_i cycles, held while owned
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i || !bus_req_i)
    begin
      gcnt <= 4'h0;
      bus_gnt_o <= 1'b0;
    end
    else if (gcnt >= wait_i)
      bus_gnt_o <= 1'b1;
    else
      gcnt <= gcnt + 4'h1;
  // one answer per access; writes land at that edge
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      rcnt <= 4'h0;
      mem_ready_o <= 1'b0;
      mem_err_o <= 1'b0;
    end
    else if (mem_ready_o)
    begin
      if (mem_req_i.write && !mem_err_o)
        mem[mem_req_i.addr[7:2]] <= mem_req_i.wdata;
      rcnt <= 4'h0;
      mem_ready_o <= 1'b0;
      mem_err_o <= 1'b0;
    end
    else if (mem_req_i.valid && rcnt >= wait_i)
    begin
      mem_ready_o <= 1'b1;
      mem_err_o <= err_en_i;
    end
    else if (mem_req_i.valid)
      rcnt <= rcnt + 4'h1;
  // data only while answering, else toggling
  always @(posedge clk_i)
    flip <= ~flip;
  assign mem_rdata_o = mem_ready_o ? mem[mem_req_i.addr[7:2]] : {32{flip}};
endmodule

/* File: two_channel_descriptor_dma_tb.sv */
// self-checking testbench for the two-channel dma
`include "tdma_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module two_channel_descriptor_dma_tb
  import tdma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] ext_n = 2'h3;
  logic [3:0] wt = 4'h0;
  logic err_en = 1'b0;
  logic [31:0] prdata, mrdata, rq;
  logic pready, pslverr, bus_req, gnt, mrdy, merr, irq, re;
  tdma_mem_req_t mreq;
  int checked = 0;
  int err_total = 0;
  int cyc = 0;
  localparam logic [11:0] STAT = {4'h0, `TDMA_OFF_STAT};
  ////////////////////////////////////////////////////////////////////////////////
  tdma_top dut_u (.clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_dma_request_n_i(ext_n), .bus_req_o(bus_req),
    .bus_gnt_i(gnt), .mem_req_o(mreq), .mem_ready_i(mrdy), .mem_err_i(merr),
    .mem_rdata_i(mrdata), .irq_o(irq));
  tdma_mem_model mem_u (.clk_i(clk), .resetn_i(resetn), .bus_req_i(bus_req), .bus_gnt_o(gnt),
    .mem_req_i(mreq), .mem_ready_o(mrdy), .mem_err_o(merr), .mem_rdata_o(mrdata),
    .wait_i(wt), .err_en_i(err_en));
  // clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] ra(input logic c, input logic [2:0] idx);
    ra = {6'h00, c, idx, 2'b00};
  endfunction
  // one register access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rq)
  endtask
  // control last: its write copies the rest; control words all enable irq
  task automatic prog(input logic c, input logic [31:0] s, ds, n, cv);
    apb(1'b1, ra(c, `TDMA_OFF_SRCB), s);
    apb(1'b1, ra(c, `TDMA_OFF_DSTB), ds);
    apb(1'b1, ra(c, `TDMA_OFF_TCNT), n);
    apb(1'b1, ra(c, `TDMA_OFF_CTL), cv);
  endtask
  task automatic wait_quiet();
    int q;
    q = 0;
    while (q < 8)
    begin
      @(posedge clk);
      q = bus_req ? 0 : q + 1;
    end
  endtask
  task automatic pulse(input int c);
    @(posedge clk);
    ext_n[c] <= 1'b0;
    repeat (2) @(posedge clk);
    ext_n[c] <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk("ptr0", ra(1'b0, `TDMA_OFF_DADR), `TDMA_DADR_RST_VAL);
    rdchk("ptr1", ra(1'b1, `TDMA_OFF_DADR), `TDMA_DADR_RST_VAL);
    rdchk("unmapped", 12'h050, 32'h0);
    `CHK("unmapped err", 1'b1, re)
  endtask
  task automatic t_soft();
    for (int i = 0; i < 3; i++) mem_u.mem[16 + i] = 32'ha5a5_0000 + i;
    prog(1'b0, 32'h40, 32'h80, 32'h3, 32'h0001_2401);
    wait_quiet();
    for (int i = 0; i < 3; i++) `CHK("copy", 32'ha5a5_0000 + i, mem_u.mem[32 + i])
    rdchk("count", ra(1'b0, `TDMA_OFF_CTCNT), 32'h0);
    rdchk("src end", ra(1'b0, `TDMA_OFF_CSRC), 32'h4c);
    rdchk("done", STAT, 32'h1);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, STAT, 32'h1);
    rdchk("done clr", STAT, 32'h0);
    `CHK("irq clr", 1'b0, irq)
  endtask
  task automatic t_block();
    prog(1'b1, 32'h63, 32'h90, 32'h4, 32'h0002_0425);
    wait_quiet();
    rdchk("no request", ra(1'b1, `TDMA_OFF_CTCNT), 32'h4);
    pulse(1);
    wait_quiet();
    rdchk("block cnt", ra(1'b1, `TDMA_OFF_CTCNT), 32'h0);
    rdchk("byte dec", ra(1'b1, `TDMA_OFF_CSRC), 32'h5f);
    rdchk("byte inc", ra(1'b1, `TDMA_OFF_CDST), 32'h94);
  endtask
  task automatic t_single();
    prog(1'b0, 32'h40, 32'ha0, 32'h6, 32'h0000_240b);
    pulse(0);
    wait_quiet();
    rdchk("burst", ra(1'b0, `TDMA_OFF_CTCNT), 32'h2);
    pulse(0);
    wait_quiet();
    rdchk("short burst", ra(1'b0, `TDMA_OFF_CDST), 32'hb8);
  endtask
  task automatic t_demand();
    logic [31:0] a;
    prog(1'b1, 32'h40, 32'hc0, 32'h28, 32'h0000_a405);
    ext_n[1] <= 1'b0;
    repeat (40) @(posedge clk);
    ext_n[1] <= 1'b1;
    wait_quiet();
    apb(1'b0, ra(1'b1, `TDMA_OFF_CTCNT), 32'h0);
    a = rq;
    repeat (30) @(posedge clk);
    `CHK("moved", 1'b1, a > 32'h0 && a < 32'h28)
    rdchk("stopped", ra(1'b1, `TDMA_OFF_CTCNT), a);
  endtask
  task automatic t_desc();
    logic [31:0] cb;
    cb = (32'h2 << `TDMA_CMD_CNT_LSB) | 32'h0001_2401;
    wt <= 4'h3;
    mem_u.mem[0] = 32'h18;
    mem_u.mem[1] = 32'h40;
    mem_u.mem[2] = 32'he0;
    mem_u.mem[3] = cb - (32'h1 << `TDMA_CMD_CNT_LSB);
    mem_u.mem[4] = 32'h4;
    mem_u.mem[5] = 32'h44;
    mem_u.mem[6] = 32'hf0;
    mem_u.mem[7] = cb;
    for (int i = 16; i < 19; i++) mem_u.mem[i] = 32'h5a00_0000 + i;
    apb(1'b1, ra(1'b0, `TDMA_OFF_DADR), 32'h4);
    apb(1'b1, ra(1'b0, `TDMA_OFF_DADR), 32'h8);
    wait_quiet();
    `CHK("list a", 32'h5a00_0010, mem_u.mem[56])
    `CHK("list b", 32'h5a00_0012, mem_u.mem[61])
    rdchk("src load", ra(1'b0, `TDMA_OFF_SRCB), 32'h44);
    rdchk("cnt load", ra(1'b0, `TDMA_OFF_TCNT), 32'h2);
    rdchk("ctl load", ra(1'b0, `TDMA_OFF_CTL), cb & 32'h3ffff);
    rdchk("next ptr", ra(1'b0, `TDMA_OFF_DADR), 32'h4);
    wt <= 4'h0;
  endtask
  task automatic t_err();
    logic [11:0] p;
    p = ra(1'b1, `TDMA_OFF_DADR);
    err_en <= 1'b1;
    apb(1'b1, p, 32'h28);
    wait_quiet();
    err_en <= 1'b0;
    apb(1'b0, p, 32'h0);
    `CHK("run clr", 1'b0, rq[`TDMA_DADR_BIT_RUN])
    apb(1'b0, STAT, 32'h0);
    `CHK("err flag", 1'b1, rq[5])
    apb(1'b1, p, 32'h1);
    rdchk("ch reset", p, `TDMA_DADR_CHRST_VAL);
    apb(1'b0, STAT, 32'h0);
    `CHK("stat clr", 2'b00, {rq[5], rq[1]})
    apb(1'b1, p, 32'h4);
    rdchk("ptr dflt", p, `TDMA_DADR_RST_VAL);
    prog(1'b1, 32'h40, 32'h80, 32'h1, 32'h0001_2401);
    wait_quiet();
    rdchk("restart", ra(1'b1, `TDMA_OFF_CTCNT), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_soft();
    t_block();
    t_single();
    t_demand();
    t_desc();
    t_err();
    results();
  end
endmodule
